// File: sim/pdrl_power_domain_asserts.sv
// Checker for the power domain block
`timescale 1ns/1ps
`default_nettype none
module pdrl_power_domain_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic backupSupplyGood,
	input wire logic analogSupplyGood,
	input wire logic mainSupplyGood,
	input wire logic backupSoftResetBit,
	input wire logic [1:0] rtcSourceSelect,
	input wire logic [2:0] powerMode,
	input wire logic lowvoltDetectEnable,
	input wire logic backupDomainReset,
	input wire logic powerResetOut,
	input wire logic onBattery,
	input wire logic rtcClockValid,
	input wire logic tamperRtcPinGpio,
	input wire logic slowOscPinsGpio,
	input wire logic regulatorOn,
	input wire logic lowvoltStatusFlag,
	input wire logic eventLine16,
	input wire logic eventInterrupt,
	input wire logic wakeRequest
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_soft; backupSoftResetBit |=> backupDomainReset; endproperty
	a_soft: assert property (p_soft) else $error("soft reset missed");
	property p_por; !backupSupplyGood [*4] |-> backupDomainReset; endproperty
	a_por: assert property (p_por) else $error("backup por missed");
	property p_only;
		(backupSupplyGood && !backupSoftResetBit) [*4] |-> !backupDomainReset;
	endproperty
	a_only: assert property (p_only) else $error("stray reset");
	property p_vld;
		(!mainSupplyGood && rtcSourceSelect != 2'h2) [*5] |-> !rtcClockValid;
	endproperty
	a_vld: assert property (p_vld) else $error("rtc valid");
	property p_bat; !mainSupplyGood [*4] |-> onBattery; endproperty
	a_bat: assert property (p_bat) else $error("no battery");
	property p_pins;
		onBattery [*2] |-> !tamperRtcPinGpio && !slowOscPinsGpio;
	endproperty
	a_pins: assert property (p_pins) else $error("gpio on battery");
	property p_stby; powerMode == 3'h3 |=> !regulatorOn; endproperty
	a_stby: assert property (p_stby) else $error("regulator on");
	property p_pwr; !analogSupplyGood [*4] |-> powerResetOut; endproperty
	a_pwr: assert property (p_pwr) else $error("power reset");
	property p_lvd;
		!lowvoltDetectEnable [*2] |-> !lowvoltStatusFlag && !eventLine16;
	endproperty
	a_lvd: assert property (p_lvd) else $error("detector off");
	property p_irq; eventInterrupt |=> !eventInterrupt; endproperty
	a_irq: assert property (p_irq) else $error("irq width");
	c_soft: cover property (backupDomainReset && backupSupplyGood);
	c_wake: cover property (wakeRequest);
	c_irq: cover property (eventInterrupt);
endmodule // pdrl_power_domain_chk
bind pdrl_power_domain pdrl_power_domain_chk u_chk (.*);
`default_nettype wire

// File: sim/test_pdrl_power_domain.sv
// Testbench for the power domain block
`timescale 1ns/1ps
`default_nettype none
module test_pdrl_power_domain;
	logic clk_sys = 0, rst_n = 0, backupSupplyGood = 1, analogSupplyGood = 1;
	logic mainSupplyGood = 1, backupSoftResetBit = 0, regLowPower = 0;
	logic [1:0] rtcSourceSelect = 0;
	logic [2:0] powerMode = 0, lowvoltThresholdField = 0;
	logic lowvoltDetectEnable = 0, lowvoltComparator = 0, eventRiseEnable = 0;
	logic eventFallEnable = 0, eventLineEnable = 0, rtcAlarmMatch = 0;
	logic rtcAlarmEnable = 0, rtcEventEnable = 0, tamperWantGpio = 0;
	logic slowOscWantGpio = 0, bkpWrite = 0;
	logic [5:0] bkpIndex = 0;
	logic [15:0] bkpWriteData = 0, bkpReadData, d;
	logic [2:0] lowvoltThresholdOut;
	logic backupDomainReset, powerResetOut, onBattery, rtcClock, rtcClockValid;
	logic tamperRtcPinGpio, slowOscPinsGpio, regulatorOn, regulatorLowPower;
	logic lowvoltStatusFlag, eventLine16, eventInterrupt, wakeRequest;
	logic [7:0] osc = 0;
	wire internalSlowRcOsc = osc[5], lowSpeedCrystalOsc = osc[4];
	wire highSpeedCrystalOsc = osc[1];
	int errors = 0, n_compared = 0, cycles = 0, i, k;
	pdrl_power_domain dut (.*);
	always #10 clk_sys = ~clk_sys;
	always @(negedge clk_sys) osc <= osc + 8'h01;
	always @(posedge clk_sys) if (++cycles == 4000) begin
		errors++;
		end_of_test;
	end
	task chk(input string n, input logic [15:0] e, s);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	function logic [1:0] expReg(input logic [2:0] m, input logic lp);
		expReg = m == 3'h3 ? 2'h0 : m == 3'h2 ? {1'b1, lp} : 2'h2;
	endfunction
	function logic vld(input logic m, input logic [1:0] s);
		vld = s != 2'h0 && (m || s == 2'h2);
	endfunction
	task end_of_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(29));
		cyc(10);
		chk("regOnRst", 1, regulatorOn);
		rst_n = 1;
		cyc(4);
		chk("bkpIdle", 0, backupDomainReset);
		i = $urandom % 42;
		d = $urandom;
		{bkpWrite, bkpIndex, bkpWriteData} = {1'b1, i[5:0], d};
		cyc(1);
		{bkpIndex, bkpWriteData} = {6'h2a, ~d};
		cyc(1);
		{bkpWrite, powerMode} = {1'b0, 3'h3};
		cyc(3);
		{powerMode, bkpIndex} = {3'h0, i[5:0]};
		cyc(2);
		chk("bkpKeep", d, bkpReadData);
		bkpIndex = 6'h2a;
		cyc(2);
		chk("bkpRange", 0, bkpReadData);
		backupSoftResetBit = 1;
		cyc(1);
		chk("softRst", 1, backupDomainReset);
		{bkpWrite, bkpIndex} = {1'b1, i[5:0]};
		cyc(2 + $urandom % 8);
		chk("softHold", 1, backupDomainReset);
		{bkpWrite, backupSoftResetBit} = 0;
		cyc(2);
		chk("softRel", 0, backupDomainReset);
		chk("bkpClr", 0, bkpReadData);
		backupSupplyGood = 0;
		cyc(4);
		chk("bkpPor", 1, backupDomainReset);
		backupSupplyGood = 1;
		cyc(4);
		chk("bkpPorRel", 0, backupDomainReset);
		{tamperWantGpio, slowOscWantGpio} = 2'h3;
		for (i = 0; i < 8; i++) begin
			{mainSupplyGood, rtcSourceSelect} = i[2:0];
			cyc(4);
			chk("battery", !i[2], onBattery);
			chk("rtcValid", vld(i[2], i[1:0]), rtcClockValid);
			chk("tamperGpio", i[2], tamperRtcPinGpio);
			chk("oscGpio", i[2], slowOscPinsGpio);
		end
		for (i = 1; i < 4; i++) begin
			rtcSourceSelect = i[1:0];
			cyc(4);
			@(posedge rtcClock) k = cycles;
			@(posedge rtcClock) k = cycles - k;
			chk("rtcPeriod", i == 3 ? 512 : 128 >> i, k);
			cyc(1);
		end
		for (i = 0; i < 4; i++) begin
			{powerMode, regLowPower} = {i[2:0], 1'($urandom)};
			cyc(1);
			chk("reg", expReg(powerMode, regLowPower), {regulatorOn, regulatorLowPower});
		end
		{powerMode, analogSupplyGood} = 0;
		cyc(4);
		chk("pwrRst", 1, powerResetOut);
		analogSupplyGood = 1;
		cyc(4);
		chk("pwrRel", 0, powerResetOut);
		repeat (8) begin
			{lowvoltThresholdField, lowvoltDetectEnable, lowvoltComparator} = $urandom;
			cyc(4);
			k = lowvoltDetectEnable & lowvoltComparator;
			chk("thr", lowvoltThresholdField, lowvoltThresholdOut);
			chk("flag", k, lowvoltStatusFlag);
			chk("line16", k, eventLine16);
		end
		{lowvoltDetectEnable, eventLineEnable, eventRiseEnable} = 3'h7;
		{lowvoltComparator, eventFallEnable} = 0;
		for (i = 1; i >= 0; i--) begin
			cyc(4);
			lowvoltComparator = i[0];
			k = 0;
			repeat (8) begin
				cyc(1);
				k += eventInterrupt;
			end
			chk("irq", i[0], k);
		end
		for (i = 1; i >= 0; i--) begin
			{rtcAlarmMatch, powerMode} = 0;
			{rtcAlarmEnable, rtcEventEnable} = {i[0], i[0]};
			cyc(1);
			powerMode = 3'h2;
			cyc(2);
			rtcAlarmMatch = 1;
			cyc(4);
			chk("wake", i[0], wakeRequest);
		end
		powerMode = 3'h0;
		k = $urandom % 42;
		d = $urandom;
		{bkpWrite, bkpIndex, bkpWriteData} = {1'b1, k[5:0], d};
		cyc(1);
		{bkpWrite, rst_n} = 0;
		cyc(3);
		chk("rstKeepBkp", 0, backupDomainReset);
		rst_n = 1;
		repeat (2) begin
			cyc(1);
			chk("rstBattery", 0, onBattery);
			chk("rstPwr", 0, powerResetOut);
		end
		chk("bkpSysRst", d, bkpReadData);
		end_of_test;
	end
endmodule // test_pdrl_power_domain
`default_nettype wire

// File: src/pdrl_defines.vh
// Constants for the power domain reset and low-voltage detect block
// What this block does
// - The backup domain is reset only by its own power-on reset or by the software backup reset.
// - Setting the backup soft reset bit resets the whole backup domain.
// - The backup power-on reset holds until the backup supply reports fully powered.
// - The RTC clock comes from the slow RC oscillator, the slow crystal, or the fast crystal divided by 128.
// - With main supply off only the slow crystal counts as a valid RTC source.
// - An RTC alarm match wakes the device from power saving if alarm and event line were enabled before entry.
// - On main supply the tamper pin may be GPIO or RTC and the oscillator pins GPIO or crystal.
// - On battery the tamper pin is RTC only and the oscillator pins are crystal only.
// - The backup supply switches to battery when the power-down reset sees main supply gone.
// - The regulator is on after reset, full in Sleep, on or low power in deep sleep, off in Standby.
// - The power reset resets everything except the backup domain while analogue supply is low.
// - The low-voltage threshold comes from a three-bit field of the power control register.
// - The low-voltage detector works only when enabled, and its flag shows above or below threshold.
// - The detector output drives event line 16, which interrupts on its configured edge when enabled.
// - Backup data registers survive system reset and Standby wake-up.
`ifndef PDRL_DEFINES_VH
`define PDRL_DEFINES_VH
`define PDRL_HIGH_SPEED_CRYSTAL_OSC_DIV 128
`define PDRL_HIGH_SPEED_CRYSTAL_OSC_HALF 6'h3f
`define PDRL_SRC_IRC 2'h1
`define PDRL_SRC_LXT 2'h2
`define PDRL_SRC_HXT 2'h3
`define PDRL_THR_W 3
`define PDRL_THR_RST 3'h0
`define PDRL_EVT_LINE 16
`define PDRL_MODE_RUN 3'h0
`define PDRL_MODE_SLEEP 3'h1
`define PDRL_MODE_DEEP 3'h2
`define PDRL_MODE_STBY 3'h3
`define PDRL_BKP_WORDS 42
`define PDRL_BKP_IDX_W 6
`endif

// File: src/pdrl_power_domain.v
// Power domain reset, backup supply, RTC source and low-voltage detect
`timescale 1ns/1ps
`default_nettype none
`include "pdrl_defines.vh"
module pdrl_power_domain #(
	parameter BKP_WORDS = `PDRL_BKP_WORDS
) (
	input wire clk_sys,
	input wire rst_n,
	input wire backupSupplyGood,
	input wire analogSupplyGood,
	input wire mainSupplyGood,
	input wire backupSoftResetBit,
	input wire [1:0] rtcSourceSelect,
	input wire internalSlowRcOsc,
	input wire lowSpeedCrystalOsc,
	input wire highSpeedCrystalOsc,
	input wire [2:0] powerMode,
	input wire regLowPower,
	input wire [`PDRL_THR_W-1:0] lowvoltThresholdField,
	input wire lowvoltDetectEnable,
	input wire lowvoltComparator,
	input wire eventRiseEnable,
	input wire eventFallEnable,
	input wire eventLineEnable,
	input wire rtcAlarmMatch,
	input wire rtcAlarmEnable,
	input wire rtcEventEnable,
	input wire tamperWantGpio,
	input wire slowOscWantGpio,
	input wire bkpWrite,
	input wire [`PDRL_BKP_IDX_W-1:0] bkpIndex,
	input wire [15:0] bkpWriteData,
	output reg [15:0] bkpReadData,
	output reg backupDomainReset,
	output reg powerResetOut,
	output reg onBattery,
	output reg rtcClock,
	output reg rtcClockValid,
	output reg tamperRtcPinGpio,
	output reg slowOscPinsGpio,
	output reg regulatorOn,
	output reg regulatorLowPower,
	output reg [`PDRL_THR_W-1:0] lowvoltThresholdOut,
	output reg lowvoltStatusFlag,
	output reg eventLine16,
	output reg eventInterrupt,
	output reg wakeRequest
);
////////////////////////////////////////////////////////////////////////
// Synchronisers for asynchronous inputs
wire bkpGoodSync;
wire anaGoodSync;
wire mainGoodSync;
wire lvdSync;
wire lscSync;
wire ircSync;
wire hxtSync;
wire alarmSync;

// Backup supply sync belongs to the backup domain, no system reset
pdrl_sync2 uBkp (
	.clk_sys(clk_sys),
	.rst_n(1'b1),
	.din(backupSupplyGood),
	.dout(bkpGoodSync)
);
// Supply syncs reset to good, so no false loss after reset
pdrl_sync2 #(
	.RST_VAL(1'b1)
) uAna (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.din(analogSupplyGood),
	.dout(anaGoodSync)
);
pdrl_sync2 #(
	.RST_VAL(1'b1)
) uMain (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.din(mainSupplyGood),
	.dout(mainGoodSync)
);
pdrl_sync2 uLvd (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.din(lowvoltComparator),
	.dout(lvdSync)
);
pdrl_sync2 uLsc (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.din(lowSpeedCrystalOsc),
	.dout(lscSync)
);
pdrl_sync2 uIrc (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.din(internalSlowRcOsc),
	.dout(ircSync)
);
pdrl_sync2 uHxt (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.din(highSpeedCrystalOsc),
	.dout(hxtSync)
);
pdrl_sync2 uAlm (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.din(rtcAlarmMatch),
	.dout(alarmSync)
);

////////////////////////////////////////////////////////////////////////
// Backup domain reset, only from its own supply or software
wire next_backupDomainReset = !bkpGoodSync || backupSoftResetBit;
always @(posedge clk_sys) begin
	backupDomainReset <= next_backupDomainReset;
end

////////////////////////////////////////////////////////////////////////
// Power reset and backup supply switch
always @(posedge clk_sys) begin
	if (!rst_n) begin
		powerResetOut <= 1'b1;
		onBattery <= 1'b0;
	end else begin
		powerResetOut <= !anaGoodSync;
		onBattery <= !mainGoodSync;
	end
end

////////////////////////////////////////////////////////////////////////
// RTC clock source, fast crystal divided by 128
reg hxtPrev;
reg [5:0] hxtCount;
reg hxtDiv;
always @(posedge clk_sys) begin
	if (!rst_n) begin
		hxtPrev <= 1'b0;
		hxtCount <= 6'h00;
		hxtDiv <= 1'b0;
	end else begin
		hxtPrev <= hxtSync;
		if (hxtSync && !hxtPrev) begin
			if (hxtCount == `PDRL_HIGH_SPEED_CRYSTAL_OSC_HALF) begin
				hxtCount <= 6'h00;
				hxtDiv <= !hxtDiv;
			end else begin
				hxtCount <= hxtCount + 6'h01;
			end
		end
	end
end
reg next_rtcClock;
reg next_rtcValid;
always @* begin
	next_rtcClock = 1'b0;
	next_rtcValid = 1'b0;
	case (rtcSourceSelect)
	`PDRL_SRC_IRC: begin
		next_rtcClock = ircSync;
		next_rtcValid = !onBattery;
	end
	`PDRL_SRC_LXT: begin
		next_rtcClock = lscSync;
		next_rtcValid = 1'b1;
	end
	`PDRL_SRC_HXT: begin
		next_rtcClock = hxtDiv;
		next_rtcValid = !onBattery;
	end
	default: begin
		next_rtcClock = 1'b0;
		next_rtcValid = 1'b0;
	end
	endcase
end
always @(posedge clk_sys) begin
	if (!rst_n) begin
		rtcClock <= 1'b0;
		rtcClockValid <= 1'b0;
	end else begin
		rtcClock <= next_rtcClock;
		rtcClockValid <= next_rtcValid;
	end
end

////////////////////////////////////////////////////////////////////////
// Pin function limits under battery supply
always @(posedge clk_sys) begin
	if (!rst_n) begin
		tamperRtcPinGpio <= 1'b0;
		slowOscPinsGpio <= 1'b0;
	end else begin
		tamperRtcPinGpio <= tamperWantGpio && !onBattery;
		slowOscPinsGpio <= slowOscWantGpio && !onBattery;
	end
end

////////////////////////////////////////////////////////////////////////
// Regulator state per power mode
always @(posedge clk_sys) begin
	if (!rst_n) begin
		regulatorOn <= 1'b1;
		regulatorLowPower <= 1'b0;
	end else begin
		case (powerMode)
		`PDRL_MODE_SLEEP: begin
			regulatorOn <= 1'b1;
			regulatorLowPower <= 1'b0;
		end
		`PDRL_MODE_DEEP: begin
			regulatorOn <= 1'b1;
			regulatorLowPower <= regLowPower;
		end
		`PDRL_MODE_STBY: begin
			regulatorOn <= 1'b0;
			regulatorLowPower <= 1'b0;
		end
		default: begin
			regulatorOn <= 1'b1;
			regulatorLowPower <= 1'b0;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Alarm wake-up, armed on entry so enables set later do not count
reg armedAlarm;
reg inSaving;
always @(posedge clk_sys) begin
	if (!rst_n) begin
		armedAlarm <= 1'b0;
		inSaving <= 1'b0;
		wakeRequest <= 1'b0;
	end else begin
		if (powerMode == `PDRL_MODE_RUN) begin
			inSaving <= 1'b0;
			armedAlarm <= 1'b0;
		end else if (!inSaving) begin
			inSaving <= 1'b1;
			armedAlarm <= rtcAlarmEnable && rtcEventEnable;
		end
		wakeRequest <= inSaving && armedAlarm && alarmSync;
	end
end

////////////////////////////////////////////////////////////////////////
// Low-voltage detector, flag and event line 16
reg lvdPrev;
wire lvdActive = lowvoltDetectEnable && lvdSync;
wire lvdRise = lvdActive && !lvdPrev;
wire lvdFall = !lvdActive && lvdPrev;
always @(posedge clk_sys) begin
	if (!rst_n) begin
		lowvoltThresholdOut <= `PDRL_THR_RST;
		lowvoltStatusFlag <= 1'b0;
		eventLine16 <= 1'b0;
		eventInterrupt <= 1'b0;
		lvdPrev <= 1'b0;
	end else begin
		lowvoltThresholdOut <= lowvoltThresholdField;
		lowvoltStatusFlag <= lvdActive;
		eventLine16 <= lvdActive;
		lvdPrev <= lvdActive;
		eventInterrupt <= eventLineEnable &&
			((eventRiseEnable && lvdRise) ||
			(eventFallEnable && lvdFall));
	end
end

////////////////////////////////////////////////////////////////////////
// Backup data, cleared only by backup domain reset
function bkpInRange;
	input [`PDRL_BKP_IDX_W-1:0] idx;
	begin
		bkpInRange = idx < BKP_WORDS;
	end
endfunction

reg [15:0] bkpMem [0:BKP_WORDS-1];
integer i;
// Writes in backup reset or out of range are dropped
always @(posedge clk_sys) begin
	if (backupDomainReset) begin
		for (i = 0; i < BKP_WORDS; i = i + 1) begin
			bkpMem[i] <= 16'h0000;
		end
	end else if (bkpWrite && bkpInRange(bkpIndex)) begin
		bkpMem[bkpIndex] <= bkpWriteData;
	end
end

always @(posedge clk_sys) begin
	if (!rst_n) begin
		bkpReadData <= 16'h0000;
	end else if (bkpInRange(bkpIndex)) begin
		bkpReadData <= bkpMem[bkpIndex];
	end else begin
		bkpReadData <= 16'h0000;
	end
end
endmodule // pdrl_power_domain
`default_nettype wire

// File: src/pdrl_sync2.v
// Two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module pdrl_sync2 #(
	parameter [0:0] RST_VAL = 1'b0
) (
	input wire clk_sys,
	input wire rst_n,
	input wire din,
	output reg dout
);
reg stage1;
always @(posedge clk_sys) begin
	if (!rst_n) begin
		stage1 <= RST_VAL;
		dout <= RST_VAL;
	end else begin
		stage1 <= din;
		dout <= stage1;
	end
end
endmodule // pdrl_sync2
`default_nettype wire
